// ### rtl/basic_cycle_sync_unit.sv
// Purpose: Makes the basic sampling tick and task triggers, self-timed or
//          synchronized to a peer on the backplane, with loss fallback.
// Assumes: Backplane and task inputs are synchronous to ref_clk_in.
// Notes on behaviour
// - Tick source drives tick onto chosen lines.
// - Receiver delays its tick by the offset.
// - Offset is rewritable while running.
// - Task pulse sent at task start or end.
// - Received interrupt pulse can make the tick.
// - Received interrupt pulse can trigger a task.
// - Four missed periods switch to local timer.
// - Fallback runs at equivalent sampling period.
// - Fallback sets error flag and blinks fault.
// - Only re-enable command leaves fallback.
// - Self period settable 0.1 to 16 ms.
// - Tick transmit needs a line, off after reset.
// - Sync source: basic-cycle line or interrupt line.
// - Equivalent period 0.1 to 16 ms, 1 ms default.
// - Delay up to equivalent period, default none.
// - Eight tasks, source bus irq or counters.
// - Each task has its own equivalent period.
// - After reset no task source, no transmit.
// - One selected task pulse sent on lines.
// - Start pulse: receivers start without delay.
// - End pulse: receivers start after sender done.
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/100ps
module basic_cycle_sync_unit #(
  parameter int TBASE = sync_unit_pkg::TBASE_CYCLES  // Clock cycles per 0.1 ms.
) (
  // Clock and reset.
  input  wire logic                           ref_clk_in,
  input  wire logic                           rst_in,
  // Register port.
  input  wire sync_unit_pkg::bus_req_s        reg_req_in,
  output logic [31:0]                         reg_rdata_out,
  // Backplane lines.
  input  wire sync_unit_pkg::backplane_s      bp_in,
  output sync_unit_pkg::backplane_s           bp_out,
  // Local task and counter events.
  input  wire logic [7:0]                     task_begin_in,
  input  wire logic [7:0]                     task_end_in,
  input  wire logic                           local_counter_a_in,
  input  wire logic                           local_counter_b_in,
  // Tick, task triggers and fault state.
  output logic                                basic_sampling_tick_out,
  output logic [7:0]                          task_trigger_out,
  output logic                                fault_blink_out,
  output logic                                fallback_out
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    sync_unit_pkg::ctrl_s             ctrl;      // Mode and transmit options.
    logic [7:0]                       period;    // Self-generate period.
    logic [7:0]                       equiv;     // Equivalent sampling period.
    logic [7:0]                       delay;     // Offset after a received tick.
    logic [15:0]                      task_src;  // Two bits per task.
    logic [63:0]                      task_per;  // One byte per task.
    logic                             fallback;  // Local timer has taken over.
    logic                             err;       // Sticky loss error.
    logic [sync_unit_pkg::WDOG_W-1:0] wdog;      // Units since last tick.
    logic [sync_unit_pkg::BLINK_W-1:0] blink_cnt; // Units in blink phase.
    logic                             blink;     // Fault indication.
    logic [sync_unit_pkg::TB_W-1:0]   presc;     // Timebase prescaler.
    logic                             unit;      // Pulse per 0.1 ms.
    logic                             armed;     // Delay timer running.
    logic                             tick;      // Basic sampling tick.
    sync_unit_pkg::backplane_s        bp;        // Driven backplane pulses.
    logic [7:0]                       trig;      // Task triggers.
    logic [31:0]                      rdata;     // Read answer.
  } main_state_s;

  main_state_s s_q;  // Registered state.
  main_state_s s_d;  // Next state.

  // Clamp a written time value into 0.1 ms .. 16 ms.
  function automatic logic [7:0] clamp_units(input logic [7:0] v);
    if (v < sync_unit_pkg::UNIT_MIN) begin
      return sync_unit_pkg::UNIT_MIN;
    end else if (v > sync_unit_pkg::UNIT_MAX) begin
      return sync_unit_pkg::UNIT_MAX;
    end
    return v;
  endfunction : clamp_units

  // Pick the event that feeds a task from its source code.
  function automatic logic pick_src(input logic [1:0] src, input logic cbus,
                                    input logic ca, input logic cb);
    case (src)
      sync_unit_pkg::SRC_CBUS: return cbus;
      sync_unit_pkg::SRC_CNTA: return ca;
      sync_unit_pkg::SRC_CNTB: return cb;
      default:                 return 1'b0;
    endcase
  endfunction : pick_src

  // ---------------------------------------------------------------
  // Edge detection and timers
  // ---------------------------------------------------------------
  // Watchdog-width value, used for size casts of watchdog arithmetic.
  typedef logic [sync_unit_pkg::WDOG_W-1:0] wdog_t;

  logic [21:0] rise;        // Rising edges of all event inputs.
  logic        bp_tick_l_e; // Local bus tick line edge.
  logic        bp_tick_c_e; // Communication bus tick line edge.
  logic        bp_irq_l_e;  // Local bus interrupt line edge.
  logic        bp_irq_c_e;  // Communication bus interrupt line edge.
  logic        cnt_a_e;     // Counter a event.
  logic        cnt_b_e;     // Counter b event.
  logic [7:0]  beg_e;       // Task begin events.
  logic [7:0]  end_e;       // Task end events.
  logic        local_run;   // Local timer enabled.
  logic        local_fire;  // Local timer tick.
  logic        delay_fire;  // Delay timer expiry.
  logic [7:0]  eff_delay;   // Delay limited to the equivalent period.
  logic        ext_e;       // Selected received tick.
  logic        synced;      // Following the received tick.
  logic [9:0]  loss_limit;  // Units without a tick before fallback.
  logic        trip;        // Watchdog has expired.
  logic        irq_evt;     // Selected task event to send.
  logic        wr_status;   // Write to the status register.

  pulse_edge #(.N(22)) u_edges (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .lines_in   ({task_end_in, task_begin_in, local_counter_b_in,
                  local_counter_a_in, bp_in}),
    .rise_out   (rise)
  );

  assign {end_e, beg_e, cnt_b_e, cnt_a_e,
          bp_tick_l_e, bp_tick_c_e, bp_irq_l_e, bp_irq_c_e} = rise;

  // Self mode uses the period, fallback the equivalent period.
  assign local_run = !s_q.ctrl.sync || s_q.fallback;

  interval_timer #(.W(sync_unit_pkg::UNIT_W)) u_local (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .run_in     (local_run),
    .unit_in    (s_q.unit),
    .limit_in   (s_q.ctrl.sync ? s_q.equiv : s_q.period),
    .fire_out   (local_fire)
  );

  // The offset is read at use, so a new value applies at once, also to a delay already running.
  assign eff_delay = (s_q.delay > s_q.equiv) ? s_q.equiv : s_q.delay;

  interval_timer #(.W(sync_unit_pkg::UNIT_W)) u_delay (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .run_in     (s_q.armed && !ext_e),
    .unit_in    (s_q.unit),
    .limit_in   (eff_delay),
    .fire_out   (delay_fire)
  );

  // ---------------------------------------------------------------
  // Combinational decisions
  // ---------------------------------------------------------------
  // Source is the tick line or the interrupt line of the chosen bus.
  always_comb begin
    case ({s_q.ctrl.src_irq, s_q.ctrl.src_c})
      2'b00:   ext_e = bp_tick_l_e;
      2'b01:   ext_e = bp_tick_c_e;
      2'b10:   ext_e = bp_irq_l_e;
      default: ext_e = bp_irq_c_e;
    endcase
  end

  assign synced     = s_q.ctrl.sync && !s_q.fallback;
  assign loss_limit = wdog_t'(s_q.equiv) * sync_unit_pkg::LOSS_PERIODS;
  assign trip       = synced && (s_q.wdog >= loss_limit);
  // Start pulse lets receivers run alongside; end pulse waits for completion.
  assign irq_evt    = s_q.ctrl.irq_at_end ? end_e[s_q.ctrl.irq_task]
                                          : beg_e[s_q.ctrl.irq_task];
  assign wr_status  = reg_req_in.wr && (reg_req_in.addr == sync_unit_pkg::REG_STATUS);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Prescaler makes one pulse per time unit.
    s_d.unit = 1'b0;
    if (s_q.presc >= sync_unit_pkg::TB_W'(TBASE - 1)) begin
      s_d.presc = '0;
      s_d.unit  = 1'b1;
    end else begin
      s_d.presc = s_q.presc + sync_unit_pkg::TB_W'(1);
    end

    // Register writes; time values are clamped to the legal range.
    if (reg_req_in.wr) begin
      case (reg_req_in.addr)
        sync_unit_pkg::REG_CTRL:
          s_d.ctrl = sync_unit_pkg::ctrl_s'(reg_req_in.wdata[sync_unit_pkg::CTRL_W-1:0]);
        sync_unit_pkg::REG_PERIOD: s_d.period = clamp_units(reg_req_in.wdata[7:0]);
        sync_unit_pkg::REG_EQUIV:  s_d.equiv  = clamp_units(reg_req_in.wdata[7:0]);
        sync_unit_pkg::REG_DELAY: begin
          // Zero means no delay; any other value is clamped.
          s_d.delay = (reg_req_in.wdata[7:0] == 8'h00) ? 8'h00
                                                       : clamp_units(reg_req_in.wdata[7:0]);
        end
        sync_unit_pkg::REG_TASK_SRC: s_d.task_src = reg_req_in.wdata[15:0];
        default: begin
          // Per-task periods; other addresses are ignored.
          if (reg_req_in.addr[5]) begin
            s_d.task_per[reg_req_in.addr[4:2]*8 +: 8] = clamp_units(reg_req_in.wdata[7:0]);
          end
        end
      endcase
    end

    // Leaving fallback needs the re-enable command; set wins over clear.
    if (wr_status && reg_req_in.wdata[sync_unit_pkg::ST_REENABLE]) begin
      s_d.fallback = 1'b0;
    end
    if (wr_status && reg_req_in.wdata[sync_unit_pkg::ST_CLR_ERR]) begin
      s_d.err = 1'b0;
    end
    if (trip) begin
      s_d.fallback = 1'b1;
      s_d.err      = 1'b1;
    end

    // Watchdog restarts on each received tick.
    if (!synced || ext_e || trip) begin
      s_d.wdog = '0;
    end else if (s_q.unit) begin
      s_d.wdog = s_q.wdog + wdog_t'(1);
    end

    // Blink toggles every blink phase while in fallback.
    if (!s_q.fallback) begin
      s_d.blink_cnt = '0;
      s_d.blink     = 1'b0;
    end else if (s_q.unit) begin
      if (s_q.blink_cnt >= sync_unit_pkg::BLINK_UNITS - 12'h001) begin
        s_d.blink_cnt = '0;
        s_d.blink     = !s_q.blink;
      end else begin
        s_d.blink_cnt = s_q.blink_cnt + 12'h001;
      end
    end

    // A received tick arms the delay; a later tick restarts it.
    if (synced && ext_e && (eff_delay != 8'h00)) begin
      s_d.armed = 1'b1;
    end else if (delay_fire || !synced) begin
      s_d.armed = 1'b0;
    end

    // Tick: direct, delayed, or from the local timer.
    s_d.tick = (synced && ext_e && (eff_delay == 8'h00))
            || (synced && s_q.armed && delay_fire)
            || (local_run && local_fire);
    s_d.bp.tick_l = s_d.tick && s_q.ctrl.tx_l;
    s_d.bp.tick_c = s_d.tick && s_q.ctrl.tx_c;
    s_d.bp.irq_l  = irq_evt && s_q.ctrl.irq_tx_l;
    s_d.bp.irq_c  = irq_evt && s_q.ctrl.irq_tx_c;

    // Task triggers follow their configured source.
    for (int i = 0; i < sync_unit_pkg::NUM_TASKS; i++) begin
      s_d.trig[i] = pick_src(s_q.task_src[2*i +: 2], bp_irq_c_e, cnt_a_e, cnt_b_e);
    end

    // Read answer stands for one cycle only.
    s_d.rdata = '0;
    if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        sync_unit_pkg::REG_CTRL:     s_d.rdata = 32'(s_q.ctrl);
        sync_unit_pkg::REG_PERIOD:   s_d.rdata = 32'(s_q.period);
        sync_unit_pkg::REG_EQUIV:    s_d.rdata = 32'(s_q.equiv);
        sync_unit_pkg::REG_DELAY:    s_d.rdata = 32'(s_q.delay);
        sync_unit_pkg::REG_STATUS:   s_d.rdata = 32'({s_q.err, s_q.fallback, synced});
        sync_unit_pkg::REG_TASK_SRC: s_d.rdata = 32'(s_q.task_src);
        default: begin
          if (reg_req_in.addr[5]) begin
            s_d.rdata = 32'(s_q.task_per[reg_req_in.addr[4:2]*8 +: 8]);
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Reset leaves every transmit option off and no task source set.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q          <= '0;
      s_q.period   <= sync_unit_pkg::PERIOD_RST;
      s_q.equiv    <= sync_unit_pkg::EQUIV_RST;
      s_q.delay    <= sync_unit_pkg::DELAY_RST;
      s_q.task_per <= {8{sync_unit_pkg::EQUIV_RST}};
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_out           = s_q.rdata;
  assign bp_out                  = s_q.bp;
  assign basic_sampling_tick_out = s_q.tick;
  assign task_trigger_out        = s_q.trig;
  assign fault_blink_out         = s_q.blink;
  assign fallback_out            = s_q.fallback;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_tick_on_bus: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (bp_out.tick_l || bp_out.tick_c) |-> basic_sampling_tick_out)
    else $error("Backplane tick without own tick.");

  a_tx_gated: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !$past(s_q.ctrl.tx_l) |-> !bp_out.tick_l)
    else $error("Tick driven on local bus while disabled.");

  a_direct_tick: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (synced && ext_e && eff_delay == 8'h00) |=> basic_sampling_tick_out)
    else $error("Undelayed received tick not passed on.");

  a_loss_trip: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (synced && s_q.wdog >= loss_limit) |=> (fallback_out && s_q.err))
    else $error("Watchdog expiry did not enter fallback.");

  a_fallback_holds: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (fallback_out && !(wr_status && reg_req_in.wdata[sync_unit_pkg::ST_REENABLE]))
      |=> fallback_out)
    else $error("Fallback left without re-enable.");

  a_blink_idle: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !fallback_out |=> !fault_blink_out)
    else $error("Fault blinks outside fallback.");

  a_irq_send: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (irq_evt && s_q.ctrl.irq_tx_c) |=> bp_out.irq_c)
    else $error("Task pulse not sent on communication bus.");

  a_task_none: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (s_q.task_src[1:0] == sync_unit_pkg::SRC_NONE) |=> !task_trigger_out[0])
    else $error("Task without source was triggered.");

  a_rdata_idle: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !reg_req_in.rd |=> (reg_rdata_out == 32'h0000_0000))
    else $error("Read data present without a read.");
endmodule : basic_cycle_sync_unit

// ### rtl/sync_unit_pkg.sv
// Purpose: Shared constants and carriers for the basic cycle sync unit.
// Assumes: 100 MHz system clock; time values are counted in 0.1 ms units.
// Notes:   Register addresses are byte addresses of aligned 32-bit words.
package sync_unit_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int UNIT_NS        = 100_000;            // One time unit is 0.1 ms.
  localparam int CLK_NS         = 10;                 // System clock period.
  localparam int TBASE_CYCLES   = UNIT_NS / CLK_NS;   // Clock cycles per time unit.
  localparam int TB_W           = 16;                 // Prescaler counter width.
  localparam int UNIT_W         = 8;                  // Width of a time value.
  localparam logic [7:0] UNIT_MIN   = 8'h01;          // 0.1 ms.
  localparam logic [7:0] UNIT_MAX   = 8'hA0;          // 16 ms.
  localparam logic [7:0] PERIOD_RST = 8'h0A;          // 1.0 ms self period.
  localparam logic [7:0] EQUIV_RST  = 8'h0A;          // 1.0 ms equivalent period.
  localparam logic [7:0] DELAY_RST  = 8'h00;          // No delay.
  localparam int WDOG_W         = 10;                 // Watchdog counter width.
  localparam logic [9:0] LOSS_PERIODS = 10'h004;      // Missed periods before fallback.
  localparam int BLINK_W        = 12;                 // Blink counter width.
  localparam logic [11:0] BLINK_UNITS = 12'h09C4;     // 250 ms per blink phase.

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam logic [5:0] REG_CTRL     = 6'h00;
  localparam logic [5:0] REG_PERIOD   = 6'h04;
  localparam logic [5:0] REG_EQUIV    = 6'h08;
  localparam logic [5:0] REG_DELAY    = 6'h0C;
  localparam logic [5:0] REG_STATUS   = 6'h10;
  localparam logic [5:0] REG_TASK_SRC = 6'h14;
  localparam logic [5:0] REG_TASK_PER = 6'h20;        // Eight words, one per task.
  localparam int CTRL_W       = 11;
  localparam int ST_REENABLE  = 0;                    // Write one: re-enable, leave fallback.
  localparam int ST_CLR_ERR   = 1;                    // Write one: clear error flag.
  localparam int NUM_TASKS    = 8;

  // Trigger source codes of an interrupt task.
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_CBUS = 2'h1;
  localparam logic [1:0] SRC_CNTA = 2'h2;
  localparam logic [1:0] SRC_CNTB = 2'h3;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  // Control word; first field is the most significant bit.
  typedef struct packed {
    logic [2:0] irq_task;    // Bits 10:8, task whose pulse goes out.
    logic       irq_at_end;  // Bit 7, send at task end instead of start.
    logic       irq_tx_c;    // Bit 6, send task pulse on communication bus.
    logic       irq_tx_l;    // Bit 5, send task pulse on local bus.
    logic       tx_c;        // Bit 4, send tick on communication bus.
    logic       tx_l;        // Bit 3, send tick on local bus.
    logic       src_c;       // Bit 2, receive from communication bus.
    logic       src_irq;     // Bit 1, receive interrupt line, not tick line.
    logic       sync;        // Bit 0, synchronized mode.
  } ctrl_s;

  // Register port request.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [5:0]  addr;
    logic [31:0] wdata;
  } bus_req_s;

  // The four backplane lines.
  typedef struct packed {
    logic tick_l;
    logic tick_c;
    logic irq_l;
    logic irq_c;
  } backplane_s;

endpackage : sync_unit_pkg

// ### rtl/pulse_edge.sv
// Purpose: Registered rising-edge detector for a vector of event lines.
// Assumes: Inputs are synchronous to the clock.
// Notes:   One cycle of latency from a line rising to its pulse.
`timescale 1ns/100ps
module pulse_edge #(
  parameter int N = 4
) (
  input  wire logic         ref_clk_in,
  input  wire logic         rst_in,
  input  wire logic [N-1:0] lines_in,
  output logic      [N-1:0] rise_out
);
  // State: previous line levels and the detected pulses.
  typedef struct packed {
    logic [N-1:0] prev;
    logic [N-1:0] rise;
  } edge_state_s;

  edge_state_s s_q;  // Registered state.
  edge_state_s s_d;  // Next state.

  // A pulse marks a line that was low and is now high.
  always_comb begin
    s_d.prev = lines_in;
    s_d.rise = lines_in & ~s_q.prev;
  end

  // Register the state.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rise_out = s_q.rise;
endmodule : pulse_edge

// ### rtl/interval_timer.sv
// Purpose: Counts time units and fires once each time the limit is reached.
// Assumes: unit_in is a one-cycle pulse per time unit.
// Notes:   Held cleared while run_in is low; a limit of zero acts as one.
`timescale 1ns/100ps
module interval_timer #(
  parameter int W = 8
) (
  input  wire logic         ref_clk_in,
  input  wire logic         rst_in,
  input  wire logic         run_in,
  input  wire logic         unit_in,
  input  wire logic [W-1:0] limit_in,
  output logic              fire_out
);
  typedef struct packed {
    logic [W-1:0] count;
    logic         fire;
  } timer_state_s;

  timer_state_s s_q;  // Registered state.
  timer_state_s s_d;  // Next state.

  // Count units; on the last one restart from zero and fire.
  always_comb begin
    s_d = s_q;
    s_d.fire = 1'b0;
    if (!run_in) begin
      s_d.count = '0;
    end else if (unit_in) begin
      if ((s_q.count + W'(1)) >= limit_in) begin
        s_d.count = '0;
        s_d.fire  = 1'b1;
      end else begin
        s_d.count = s_q.count + W'(1);
      end
    end
  end

  // Register the state.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign fire_out = s_q.fire;
endmodule : interval_timer

// ### verif/peer_cpu.sv
// Purpose: Behavioural peer CPU that drives the backplane lines seen by the unit.
// Assumes: One clock; the peer's period is counted in system clock cycles.
// Notes:   Idle lines sit low; the interrupt line follows irq_in directly.
`timescale 1ns/100ps
module peer_cpu #(
  parameter int PER = 100  // Cycles between transmitted ticks.
) (
  // Clock and reset.
  input  wire logic                 ref_clk_in,
  input  wire logic                 rst_in,
  // Peer controls.
  input  wire logic                 run_in,
  input  wire logic                 irq_in,
  // Backplane lines driven by the peer.
  output sync_unit_pkg::backplane_s bp_out
);
  int   cnt_q;   // Period counter.
  logic tick_q;  // One-cycle tick pulse.
  // The counter free-runs so that stopping the tick does not shift its phase.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q  <= 0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= run_in && (cnt_q == PER - 1);
      cnt_q  <= (cnt_q == PER - 1) ? 0 : cnt_q + 1;
    end
  end
  // Only the local tick line and the bus interrupt line are used by this peer.
  assign bp_out = '{tick_l: tick_q, tick_c: 1'b0, irq_l: 1'b0, irq_c: irq_in};
endmodule : peer_cpu

// ### verif/basic_cycle_sync_unit_tb.sv
// Purpose: Self-checking bench for the basic cycle sync unit and a peer CPU.
// Assumes: TBASE of 10, so one time unit is 10 cycles; peer period is 1.0 ms.
// Notes:   One 250 ms blink phase is waited out once; it dominates the run time.
`timescale 1ns/100ps
module basic_cycle_sync_unit_tb;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic                      ref_clk_in = 1'b0, rst_in = 1'b1, run = 1'b0;
  logic [2:0]                ev = '0;  // Bus interrupt, task begin, task end.
  sync_unit_pkg::bus_req_s   req = '0;
  sync_unit_pkg::backplane_s bp_in, bp_out;
  logic [31:0]               rdata;
  logic [7:0]                trig;
  logic                      tick, blink, fb;
  int                        fails = 0, tests_run = 0, n;
  always #5 ref_clk_in = ~ref_clk_in;
  peer_cpu #(.PER(100)) u_peer (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .run_in(run),
    .irq_in(ev[0]), .bp_out(bp_in));
  basic_cycle_sync_unit #(.TBASE(10)) u_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .reg_req_in(req), .reg_rdata_out(rdata), .bp_in(bp_in), .bp_out(bp_out),
    .task_begin_in({7'h00, ev[1]}), .task_end_in({7'h00, ev[2]}),
    .local_counter_a_in(ev[1]), .local_counter_b_in(ev[2]), .basic_sampling_tick_out(tick),
    .task_trigger_out(trig), .fault_blink_out(blink), .fallback_out(fb));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk_in) req <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk_in) req <= '0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so look there.
  task rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge ref_clk_in) req <= '{1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge ref_clk_in) req <= '0;
    #1 chk(rdata & m, exp);
  endtask : rd
  // Counts cycles until the tick, the peer tick or fallback is seen; bounded.
  task cnt(input int s, output int k);
    k = 0;
    do begin
      @(posedge ref_clk_in);
      #1 k++;
    end while (!(s == 0 ? tick === 1'b1 : s == 1 ? bp_in.tick_l === 1'b1 : fb === 1'b1)
               && k < 2000);
    if (k >= 2000) begin
      fails++;
      $display("ERROR t=%0t wait %h timed out after %h cycles", $time, s, k);
    end
  endtask : cnt
  // One-cycle event, then wait until its registered answer is due.
  task pulse(input logic [2:0] e);
    @(posedge ref_clk_in) ev <= e;
    @(posedge ref_clk_in) ev <= '0;
    @(posedge ref_clk_in);
    #1;
  endtask : pulse
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd(sync_unit_pkg::REG_EQUIV, '1, 32'h0000_000A);
    rd(sync_unit_pkg::REG_PERIOD, '1, 32'h0000_000A);
    rd(sync_unit_pkg::REG_DELAY, '1, 32'h0000_0000);
    rd(sync_unit_pkg::REG_CTRL, '1, 32'h0000_0000);
    rd(sync_unit_pkg::REG_TASK_SRC, '1, 32'h0000_0000);
    rd(6'h3C, '1, 32'h0000_000A);
    wr(6'h24, 32'h0000_00FF);
    rd(6'h24, '1, 32'h0000_00A0);
    chk(32'(bp_out), 32'h0000_0000);
    wr(sync_unit_pkg::REG_PERIOD, 32'h0000_0003);
    cnt(0, n);
    cnt(0, n);
    chk(32'(n), 32'h0000_001E);
    wr(sync_unit_pkg::REG_TASK_SRC, 32'h0000_0039);
    wr(sync_unit_pkg::REG_CTRL, 32'h0000_0029);
    run <= 1'b1;
    cnt(1, n);
    repeat (2) @(posedge ref_clk_in);
    #1 chk({tick, bp_out.tick_l}, 32'h0000_0003);
    wr(sync_unit_pkg::REG_DELAY, 32'h0000_0003);
    cnt(1, n);
    cnt(0, n);
    chk(32'(n >= 22 && n <= 43), 32'h0000_0001);
    pulse(3'b001);
    chk(trig, 32'h0000_0001);
    pulse(3'b010);
    chk(bp_out.irq_l, 32'h0000_0001);
    chk(trig, 32'h0000_0002);
    wr(sync_unit_pkg::REG_CTRL, 32'h0000_00A9);
    pulse(3'b100);
    chk(bp_out.irq_l, 32'h0000_0001);
    chk(trig, 32'h0000_0004);
    pulse(3'b010);
    chk(bp_out.irq_l, 32'h0000_0000);
    // Stop the peer right after its tick so the loss count starts from a known point.
    cnt(1, n);
    run <= 1'b0;
    cnt(2, n);
    chk(32'(n >= 385 && n <= 420), 32'h0000_0001);
    rd(sync_unit_pkg::REG_STATUS, 32'h0000_0006, 32'h0000_0006);
    cnt(0, n);
    cnt(0, n);
    chk(32'(n), 32'h0000_0064);
    repeat (25_000) @(posedge ref_clk_in);
    #1 chk(blink, 32'h0000_0001);
    run <= 1'b1;
    repeat (300) @(posedge ref_clk_in);
    #1 chk(fb, 32'h0000_0001);
    wr(sync_unit_pkg::REG_STATUS, 32'h0000_0001);
    repeat (2) @(posedge ref_clk_in);
    #1 chk(fb, 32'h0000_0000);
    chk(blink, 32'h0000_0000);
    wr(sync_unit_pkg::REG_DELAY, 32'h0000_0000);
    wr(sync_unit_pkg::REG_CTRL, 32'h0000_000F);
    pulse(3'b001);
    chk({tick, bp_out.tick_l}, 32'h0000_0003);
    stop_test();
  end
  // The whole sequence takes about 26400 cycles; 50000 means a hang.
  initial begin
    #500_000;
    fails++;
    stop_test();
  end
endmodule : basic_cycle_sync_unit_tb
